// ### rtl/uif_pkg.sv
// Purpose: constants and carrier types for the usb event flag and enable block
// Assumes: 10 MHz clock, AXI4-Lite register access with 32-bit data
// Notes:   register offsets are byte addresses
`default_nettype none
package uif_pkg;
   // clock
   localparam int CLK_PERIOD_NS = 100;
   // timing: line quiet / k state / se0 detection windows
   localparam int QUIET_NS      = 2500;
   localparam int QUIET_CYC     = (QUIET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int IDLE_MS       = 3;
   localparam int IDLE_CYC      = (IDLE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W         = 16;
   // register byte offsets
   localparam logic [7:0] OFF_FLAGS   = 8'h00;
   localparam logic [7:0] OFF_ENABLES = 8'h04;
   localparam logic [7:0] OFF_ERR_EN  = 8'h08;
   localparam logic [7:0] OFF_XSTAT   = 8'h0c;
   localparam logic [7:0] OFF_CTRL    = 8'h10;
   // field positions
   localparam int BIT_STALL  = 7;
   localparam int BIT_ATTACH = 6;
   localparam int BIT_RESUME = 5;
   localparam int BIT_IDLE   = 4;
   localparam int BIT_TOKEN  = 3;
   localparam int BIT_SOF    = 2;
   localparam int BIT_ERR    = 1;
   localparam int BIT_RST    = 0;
   localparam int BIT_HOST_ROLE_ENABLE = 0;
   // reset values
   localparam logic [7:0] FLAGS_RST = 8'h00;
   localparam logic [7:0] EN_RST    = 8'h00;
   // status fifo
   localparam int FIFO_DEPTH = 4;
   localparam int FIFO_AW    = 2;
   // axi responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // line state and event pulses from the link logic
   typedef struct packed {
      logic       lineK;       // k state on the data lines
      logic       lineSe0;     // single-ended zero
      logic       lineJ;       // idle (j) state
      logic       busActivity; // any packet activity, pulse
      logic       stallRx;     // stall handshake received, pulse
      logic       stallTx;     // stall handshake sent, pulse
      logic       sofRx;       // sof token received, pulse
      logic       sofThresh;   // host sof threshold reached, pulse
      logic       tokenDone;   // token processing finished, pulse
      logic [7:0] tokenStat;   // endpoint information of that token
      logic [7:0] errFlags;    // individual error flags
   } uif_link_ev_t;
endpackage
`default_nettype wire

// ### rtl/uif_usb_interrupt_flags.sv
// Purpose: usb event flags, enables, error summary and module interrupt request
// Assumes: link events synchronous to clk; one AXI4-Lite master
// Notes:   status fifo pops when software clears the token flag
//
// Overview of operation
// (R1) Bits 31 to 8 of the flag and enable registers always read zero.
// (R2) All flags but the error summary are set by hardware and cleared by writing 1.
// (R3) Stall flag sets on a received stall as host or a sent stall as device.
// (R4) Attach flag sets in host role after 2.5 us of no activity with the bus not in SE0.
// (R5) Resume flag sets after a K state held continuously for 2.5 us.
// (R6) Idle flag sets when the bus stays idle for 3 ms or longer.
// (R7) Token flag sets when a token finishes and its status is readable.
// (R8) Clearing the token flag advances the transfer status fifo.
// (R9) Frame start flag sets on a received SOF as device or the SOF threshold as host.
// (R10) Error summary is read-only and only unmasked errors drive it.
// (R11) In device role bit 0 is the bus reset flag, set on a valid USB reset.
// (R12) In host role bit 0 is the detach flag, set on a peripheral detach.
// (R13) The enable register has one read/write bit per flag, reset to zero.
// (R14) Enable bit 0 serves bus reset in device role and detach in host role.
// (R15) The error summary reaches the request only while enable bit 1 is set.
// (R16) Software keeps the resume enable off unless the link is suspended.
// (R17) The request is high while any flag and its enable are both set.
`default_nettype none
module uif_usb_interrupt_flags
   import uif_pkg::*;
#(
   parameter int IDLE_CYCLES = uif_pkg::IDLE_CYC
) (
   // clock and reset
   input  wire logic                  clk,
   input  wire logic                  sys_rst,
   // link events
   input  wire uif_pkg::uif_link_ev_t linkEv,
   output logic                       tokenReady,
   // interrupt
   output logic                       moduleInterruptRequest,
   output logic                       hostRoleEnable,
   // axi4-lite write address
   input  wire logic [7:0]            awaddr,
   input  wire logic                  awvalid,
   output logic                       awready,
   // axi4-lite write data
   input  wire logic [31:0]           wdata,
   input  wire logic [3:0]            wstrb,
   input  wire logic                  wvalid,
   output logic                       wready,
   // axi4-lite write response
   output logic [1:0]                 bresp,
   output logic                       bvalid,
   input  wire logic                  bready,
   // axi4-lite read address
   input  wire logic [7:0]            araddr,
   input  wire logic                  arvalid,
   output logic                       arready,
   // axi4-lite read data
   output logic [31:0]                rdata,
   output logic [1:0]                 rresp,
   output logic                       rvalid,
   input  wire logic                  rready
);
   import uif_pkg::*;

   function automatic logic [CNT_W-1:0] satInc(input logic [CNT_W-1:0] c, input logic run);
      if (!run) begin
         satInc = '0;
      end else if (c == '1) begin
         satInc = c;
      end else begin
         satInc = c + 1'b1;
      end
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == OFF_FLAGS) || (a == OFF_ENABLES) || (a == OFF_ERR_EN) ||
               (a == OFF_XSTAT) || (a == OFF_CTRL);
   endfunction

   localparam logic [CNT_W-1:0] QUIET_N = CNT_W'(QUIET_CYC);
   localparam logic [CNT_W-1:0] IDLE_N  = CNT_W'(IDLE_CYCLES);

   // register state
   logic [7:0]         flags, next_flags;
   logic [7:0]         enables, next_enables;
   logic [7:0]         errEnables, next_errEnables;
   logic               host_role_enable, next_host_role_enable;
   // line timers
   logic [CNT_W-1:0]   kCnt, next_kCnt;
   logic [CNT_W-1:0]   se0Cnt, next_se0Cnt;
   logic [CNT_W-1:0]   idleCnt, next_idleCnt;
   logic [CNT_W-1:0]   quietCnt, next_quietCnt;
   logic               attached, next_attached;
   // status fifo
   logic [7:0]         fifoMem [FIFO_DEPTH];
   logic [FIFO_AW-1:0] rdPtr, next_rdPtr;
   logic [FIFO_AW-1:0] wrPtr, next_wrPtr;
   logic [FIFO_AW:0]   fifoCnt, next_fifoCnt;
   // bus state
   logic [7:0]         awAddrQ, next_awAddrQ;
   logic               awHeld, next_awHeld;
   logic [31:0]        wDataQ, next_wDataQ;
   logic [3:0]         wStrbQ, next_wStrbQ;
   logic               wHeld, next_wHeld;
   logic               bvalidQ, next_bvalidQ;
   logic [1:0]         brespQ, next_brespQ;
   logic               rvalidQ, next_rvalidQ;
   logic [1:0]         rrespQ, next_rrespQ;
   logic [31:0]        rdataQ, next_rdataQ;

   logic               errSummary;
   logic [7:0]         flagView;
   logic [7:0]         pending;
   logic               doWrite;
   logic               push;
   logic               pop;
   logic               tokClr;

   assign errSummary = |(linkEv.errFlags & errEnables);  // see (R10)
   always_comb begin
      flagView         = flags;
      flagView[BIT_ERR] = errSummary;  // see (R10)
   end

   // one and term per flag position
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_pend
         assign pending[gi] = flagView[gi] & enables[gi];  // see (R15) see (R17) see (R14)
      end
   endgenerate
   assign moduleInterruptRequest = |pending;  // see (R17)
   assign hostRoleEnable         = host_role_enable;

   assign doWrite    = awHeld && wHeld && !bvalidQ;
   assign tokClr     = doWrite && (awAddrQ == OFF_FLAGS) && wStrbQ[0] && wDataQ[BIT_TOKEN];
   assign tokenReady = (fifoCnt != (FIFO_AW+1)'(FIFO_DEPTH));
   assign push       = linkEv.tokenDone && tokenReady;
   assign pop        = tokClr && (fifoCnt != '0);  // see (R8)

   // line timers and flag setting
   always_comb begin
      logic [7:0] setEv;
      logic [7:0] clrEv;
      logic [FIFO_AW:0] cntAfter;
      setEv         = '0;
      clrEv         = '0;
      cntAfter      = '0;
      next_kCnt     = satInc(kCnt, linkEv.lineK);  // see (R5)
      next_se0Cnt   = satInc(se0Cnt, linkEv.lineSe0);
      next_idleCnt  = satInc(idleCnt, linkEv.lineJ && !linkEv.busActivity);  // see (R6)
      next_quietCnt = satInc(quietCnt, !linkEv.busActivity);
      next_attached = attached;
      // stall on the handshake phase, direction by role
      setEv[BIT_STALL] = host_role_enable ? linkEv.stallRx : linkEv.stallTx;  // see (R3)
      // attach: quiet, not se0, host role, previously detached
      if (host_role_enable && !attached && quietCnt == QUIET_N && !linkEv.lineSe0) begin
         setEv[BIT_ATTACH] = 1'b1;  // see (R4)
         next_attached     = 1'b1;
      end
      setEv[BIT_RESUME] = (kCnt == QUIET_N);  // see (R5)
      setEv[BIT_IDLE]   = (idleCnt == IDLE_N);  // see (R6)
      setEv[BIT_SOF]    = host_role_enable ? linkEv.sofThresh : linkEv.sofRx;  // see (R9)
      // bit 0: bus reset as device, detach as host, both after a held se0
      if (se0Cnt == QUIET_N) begin
         if (host_role_enable) begin
            setEv[BIT_RST] = attached;  // see (R12)
            next_attached  = 1'b0;
         end else begin
            setEv[BIT_RST] = 1'b1;  // see (R11)
         end
      end
      if (!host_role_enable) begin
         next_attached = 1'b0;
      end
      // fifo bookkeeping
      next_wrPtr   = push ? wrPtr + 1'b1 : wrPtr;
      next_rdPtr   = pop ? rdPtr + 1'b1 : rdPtr;
      next_fifoCnt = fifoCnt + (FIFO_AW+1)'(push) - (FIFO_AW+1)'(pop);
      cntAfter     = fifoCnt - (FIFO_AW+1)'(pop);
      // token flag stays up while older entries remain
      setEv[BIT_TOKEN] = push || (tokClr && cntAfter != '0);  // see (R7) see (R8)
      if (doWrite && awAddrQ == OFF_FLAGS && wStrbQ[0]) begin
         clrEv = wDataQ[7:0];  // see (R2)
      end
      // set wins over clear; summary bit is never stored
      next_flags          = (flags & ~clrEv) | setEv;  // see (R2)
      next_flags[BIT_ERR] = 1'b0;  // see (R10)
   end

   // register writes and read answers
   always_comb begin
      next_enables    = enables;
      next_errEnables = errEnables;
      next_host_role_enable     = host_role_enable;
      next_awAddrQ    = awAddrQ;
      next_awHeld     = awHeld;
      next_wDataQ     = wDataQ;
      next_wStrbQ     = wStrbQ;
      next_wHeld      = wHeld;
      next_bvalidQ    = bvalidQ;
      next_brespQ     = brespQ;
      next_rvalidQ    = rvalidQ;
      next_rrespQ     = rrespQ;
      next_rdataQ     = rdataQ;
      if (awvalid && awready) begin
         next_awAddrQ = awaddr;
         next_awHeld  = 1'b1;
      end
      if (wvalid && wready) begin
         next_wDataQ = wdata;
         next_wStrbQ = wstrb;
         next_wHeld  = 1'b1;
      end
      if (bvalidQ && bready) begin
         next_bvalidQ = 1'b0;
      end
      if (doWrite) begin
         next_awHeld  = 1'b0;
         next_wHeld   = 1'b0;
         next_bvalidQ = 1'b1;
         next_brespQ  = mapped(awAddrQ) ? RESP_OKAY : RESP_SLVERR;
         // only byte lane 0 carries implemented bits
         if (wStrbQ[0]) begin
            case (awAddrQ)
               OFF_ENABLES: next_enables    = wDataQ[7:0];  // see (R13)
               OFF_ERR_EN:  next_errEnables = wDataQ[7:0];
               OFF_CTRL:    next_host_role_enable     = wDataQ[BIT_HOST_ROLE_ENABLE];
               default:     next_host_role_enable     = host_role_enable;
            endcase
         end
      end
      if (rvalidQ && rready) begin
         next_rvalidQ = 1'b0;
      end
      if (arvalid && arready) begin
         next_rvalidQ = 1'b1;
         next_rrespQ  = mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
         case (araddr)
            OFF_FLAGS:   next_rdataQ = {24'h000000, flagView};  // see (R1)
            OFF_ENABLES: next_rdataQ = {24'h000000, enables};  // see (R1)
            OFF_ERR_EN:  next_rdataQ = {24'h000000, errEnables};
            OFF_XSTAT:   next_rdataQ = {24'h000000, fifoMem[rdPtr]};  // see (R7)
            OFF_CTRL:    next_rdataQ = {31'h00000000, host_role_enable};
            default:     next_rdataQ = 32'h00000000;
         endcase
      end
   end

   assign awready = !awHeld;
   assign wready  = !wHeld;
   assign arready = !rvalidQ;
   assign bvalid  = bvalidQ;
   assign bresp   = brespQ;
   assign rvalid  = rvalidQ;
   assign rresp   = rrespQ;
   assign rdata   = rdataQ;

   always_ff @(posedge clk) begin
      if (push) begin
         fifoMem[wrPtr] <= linkEv.tokenStat;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         flags      <= FLAGS_RST;  // see (R2)
         enables    <= EN_RST;  // see (R13)
         errEnables <= EN_RST;
         host_role_enable     <= 1'b0;
         kCnt       <= '0;
         se0Cnt     <= '0;
         idleCnt    <= '0;
         quietCnt   <= '0;
         attached   <= 1'b0;
         rdPtr      <= '0;
         wrPtr      <= '0;
         fifoCnt    <= '0;
         awAddrQ    <= '0;
         awHeld     <= 1'b0;
         wDataQ     <= '0;
         wStrbQ     <= '0;
         wHeld      <= 1'b0;
         bvalidQ    <= 1'b0;
         brespQ     <= RESP_OKAY;
         rvalidQ    <= 1'b0;
         rrespQ     <= RESP_OKAY;
         rdataQ     <= '0;
      end else begin
         flags      <= next_flags;
         enables    <= next_enables;
         errEnables <= next_errEnables;
         host_role_enable     <= next_host_role_enable;
         kCnt       <= next_kCnt;
         se0Cnt     <= next_se0Cnt;
         idleCnt    <= next_idleCnt;
         quietCnt   <= next_quietCnt;
         attached   <= next_attached;
         rdPtr      <= next_rdPtr;
         wrPtr      <= next_wrPtr;
         fifoCnt    <= next_fifoCnt;
         awAddrQ    <= next_awAddrQ;
         awHeld     <= next_awHeld;
         wDataQ     <= next_wDataQ;
         wStrbQ     <= next_wStrbQ;
         wHeld      <= next_wHeld;
         bvalidQ    <= next_bvalidQ;
         brespQ     <= next_brespQ;
         rvalidQ    <= next_rvalidQ;
         rrespQ     <= next_rrespQ;
         rdataQ     <= next_rdataQ;
      end
   end
endmodule
`default_nettype wire

// ### testbench/uif_checker.sv
// Purpose: bus and flag timing checks for the usb event flag block
// Assumes: bound to uif_usb_interrupt_flags, one clock domain
// Notes:   flag contents are judged by the bench through register reads
`default_nettype none
module uif_checker
   import uif_pkg::*;
#(
   parameter int IDLE_CYCLES = 50
) (
   input wire logic                  clk,
   input wire logic                  sys_rst,
   input wire uif_pkg::uif_link_ev_t linkEv,
   input wire logic                  tokenReady,
   input wire logic                  moduleInterruptRequest,
   input wire logic                  hostRoleEnable,
   input wire logic                  awvalid,
   input wire logic                  awready,
   input wire logic                  wvalid,
   input wire logic                  wready,
   input wire logic                  bvalid,
   input wire logic                  bready,
   input wire logic [7:0]            araddr,
   input wire logic                  arvalid,
   input wire logic                  arready,
   input wire logic [31:0]           rdata,
   input wire logic [1:0]            rresp,
   input wire logic                  rvalid,
   input wire logic                  rready
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   chk_upper_zero: assert property (rvalid |-> rdata[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   chk_unmapped_read: assert property (arvalid && arready && araddr > 8'h10
      |=> rresp == RESP_SLVERR && rdata == 32'h0) else $error("unmapped read not refused");
   chk_read_answer: assert property (arvalid && arready |=> rvalid)
      else $error("read answer late");
   chk_read_once: assert property (rvalid && rready |=> !rvalid && arready)
      else $error("read answer repeated");
   chk_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
      else $error("write response late");
   chk_write_once: assert property (bvalid && bready |=> !bvalid)
      else $error("write response repeated");
   chk_irq_reset: assert property ($fell(sys_rst) |-> !moduleInterruptRequest)
      else $error("request high after reset");
   chk_irq_cause: assert property ($rose(moduleInterruptRequest) |-> $rose(bvalid)
      || $past(linkEv[24:16]) != 9'h0 || $changed(linkEv.errFlags))
      else $error("request rose without cause");
   chk_token_full: assert property ($fell(tokenReady) |-> $past(linkEv.tokenDone))
      else $error("status queue filled without token");
   chk_role_write: assert property ($changed(hostRoleEnable) |-> $rose(bvalid) || $past(sys_rst))
      else $error("role changed without write");
   cover property ($fell(tokenReady));
   cover property (rvalid && rresp == RESP_SLVERR);
   cover property ($rose(moduleInterruptRequest));
endmodule

bind uif_usb_interrupt_flags uif_checker #(.IDLE_CYCLES(IDLE_CYCLES)) u_chk (
   .clk(clk), .sys_rst(sys_rst), .linkEv(linkEv), .tokenReady(tokenReady),
   .moduleInterruptRequest(moduleInterruptRequest), .hostRoleEnable(hostRoleEnable),
   .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
   .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
   .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
`default_nettype wire

// ### testbench/uif_link_model.sv
// Purpose: behavioural far end of the usb link, line states and event pulses
// Assumes: driven by bench calls, changes only after a rising edge
// Notes:   token status is scrambled outside its pulse so stale data never matches
`default_nettype none
module uif_link_model
   import uif_pkg::*;
(
   input  wire logic            clk,
   output var uif_pkg::uif_link_ev_t linkEv
);
   timeunit 1ns;
   timeprecision 1ns;
   // lines report nothing until a scenario drives them, so only the quiet timer runs early
   initial linkEv = '0;
   // p = {busActivity, stallRx, stallTx, sofRx, sofThresh, tokenDone}
   task automatic pulse(input logic [5:0] p, input logic [7:0] st);
      @(posedge clk);
      {linkEv.busActivity, linkEv.stallRx, linkEv.stallTx, linkEv.sofRx,
       linkEv.sofThresh, linkEv.tokenDone} <= p;
      linkEv.tokenStat <= st;
      @(posedge clk);
      {linkEv.busActivity, linkEv.stallRx, linkEv.stallTx, linkEv.sofRx,
       linkEv.sofThresh, linkEv.tokenDone} <= 6'h00;
      linkEv.tokenStat <= ~st;
   endtask
   // l = {lineK, lineSe0, lineJ}, held for n cycles
   task automatic line(input logic [2:0] l, input int n);
      {linkEv.lineK, linkEv.lineSe0, linkEv.lineJ} <= l;
      repeat (n) @(posedge clk);
   endtask
   task automatic errs(input logic [7:0] e);
      @(posedge clk);
      linkEv.errFlags <= e;
   endtask
endmodule
`default_nettype wire

// ### testbench/uif_usb_interrupt_flags_enables_test.sv
// Purpose: self-checking bench for the usb event flag and enable block
// Assumes: axi4-lite master tasks here, link events from uif_link_model
// Notes:   idle window shortened to 50 cycles to keep the run short
`default_nettype none
module uif_usb_interrupt_flags_enables_test;
   timeunit 1ns;
   timeprecision 1ns;
   import uif_pkg::*;
   logic         clk = 1'b0, sys_rst = 1'b1, tokenReady, moduleInterruptRequest;
   logic         awvalid, awready, wvalid, wready, bvalid, bready, hostRoleEnable;
   logic         arvalid, arready, rvalid, rready;
   logic [7:0]   awaddr, araddr;
   logic [31:0]  wdata, rdata;
   logic [3:0]   wstrb;
   logic [1:0]   bresp, rresp;
   uif_link_ev_t linkEv;
   logic [33:0]  rq[$];
   logic [1:0]   bq[$];
   int           miscompares = 0, testsRun = 0, cyc = 0;
   always #50 clk = ~clk;
   uif_usb_interrupt_flags #(.IDLE_CYCLES(50)) uut (.clk(clk), .sys_rst(sys_rst),
      .linkEv(linkEv), .tokenReady(tokenReady), .hostRoleEnable(hostRoleEnable),
      .moduleInterruptRequest(moduleInterruptRequest), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
   uif_link_model link (.clk(clk), .linkEv(linkEv));
   task automatic chk(input string n, input logic [33:0] e, input logic [33:0] s);
      testsRun++;
      if (s !== e) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic finish_test();
      $display("comparisons %0d, miscompares %0d", testsRun, miscompares);
      if (miscompares == 0 && testsRun > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
      @(posedge clk);
      bq.push_back(r);
      awaddr <= a;
      wdata <= d;
      wstrb <= {3'($urandom_range(7, 0)), 1'b1};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
      @(posedge clk);
      rq.push_back({r, d});
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge clk); while (!arready);
      arvalid <= 1'b0;
   endtask
   // results are matched in arrival order, one note per answer
   always @(posedge clk) begin
      if (rvalid && rready) chk("read", rq.pop_front(), {rresp, rdata});
      if (bvalid && bready) chk("bresp", 34'(bq.pop_front()), 34'(bresp));
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         finish_test();
      end
   end
   initial begin
      logic [31:0] d;
      {awvalid, wvalid, arvalid, awaddr, araddr, wdata, wstrb} = '0;
      bready = 1'b1;
      rready = 1'b1;
      void'($urandom(25));
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
      rd(OFF_FLAGS, 32'h0);
      rd(OFF_ENABLES, 32'h0);
      rd(8'h14, 32'h0, RESP_SLVERR);
      wr(8'h14, 32'hff, RESP_SLVERR);
      d = $urandom() & 32'hffffffdf;
      wr(OFF_ENABLES, d);
      rd(OFF_ENABLES, {24'h0, d[7:0]});
      wr(OFF_ENABLES, 32'hdf);
      link.pulse(6'h10, 8'h00);
      rd(OFF_FLAGS, 32'h0);
      chk("irq", 34'h0, 34'(moduleInterruptRequest));
      link.pulse(6'h0c, 8'h00);
      rd(OFF_FLAGS, 32'h84);
      chk("irq", 34'h1, 34'(moduleInterruptRequest));
      wr(OFF_FLAGS, 32'h80);
      rd(OFF_FLAGS, 32'h04);
      link.errs(8'h05);
      rd(OFF_FLAGS, 32'h04);
      wr(OFF_ERR_EN, 32'h04);
      rd(OFF_ERR_EN, 32'h04);
      wr(OFF_FLAGS, 32'h06);
      rd(OFF_FLAGS, 32'h02);
      wr(OFF_ENABLES, 32'h02);
      chk("irq", 34'h1, 34'(moduleInterruptRequest));
      wr(OFF_ENABLES, 32'hdd);
      chk("irq", 34'h0, 34'(moduleInterruptRequest));
      link.errs(8'h00);
      // k held 20 cycles stays short of the resume window
      link.line(3'b100, 20);
      link.line(3'b000, 1);
      rd(OFF_FLAGS, 32'h0);
      link.line(3'b100, 30);
      link.line(3'b010, 30);
      link.line(3'b001, 55);
      rd(OFF_FLAGS, 32'h31);
      wr(OFF_FLAGS, 32'h31);
      // activity first so the attach quiet count restarts and reaches its window inside host role
      link.pulse(6'h20, 8'h00);
      wr(OFF_CTRL, 32'h1);
      chk("hostRole", 34'h1, 34'(hostRoleEnable));
      link.pulse(6'h2c, 8'h00);
      link.pulse(6'h12, 8'h00);
      rd(OFF_FLAGS, 32'h84);
      link.line(3'b001, 30);
      rd(OFF_FLAGS, 32'hc4);
      link.line(3'b010, 30);
      rd(OFF_FLAGS, 32'hc5);
      wr(OFF_ENABLES, 32'h01);
      chk("irq", 34'h1, 34'(moduleInterruptRequest));
      wr(OFF_FLAGS, 32'hff);
      chk("irq", 34'h0, 34'(moduleInterruptRequest));
      for (int i = 0; i < 4; i++) link.pulse(6'h01, 8'h30 + 8'(i));
      @(posedge clk);
      chk("tokenReady", 34'h0, 34'(tokenReady));
      for (int i = 0; i < 4; i++) begin
         rd(OFF_FLAGS, 32'h08);
         rd(OFF_XSTAT, 32'h30 + 32'(i));
         wr(OFF_FLAGS, 32'h08);
      end
      rd(OFF_FLAGS, 32'h0);
      repeat (3) @(posedge clk);
      finish_test();
   end
endmodule
`default_nettype wire
